// [rstpf_pkg.sv]
/*
  constants and types shared by the reset pin and pin function select logic.
  assumes one clock domain at 250 mhz and a synchronous, active high system reset.
*/
package rstpf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam real CLOCK_PERIOD_NS = 4.0;
  localparam int RELEASE_CYCLES = 32;
  localparam int RELEASE_COUNT_WIDTH = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // pins and reset values
  localparam int NUM_SHARED_PINS = 16;
  localparam logic PIN_LEVEL_RESET = 1'b1;
  localparam logic FUNC_PRIMARY = 1'b0;
  localparam logic GPIO_MODE_RESET = 1'b0;
  localparam logic GPIO_DIR_RESET = 1'b0;
  localparam logic GPIO_OUT_RESET = 1'b1;

  // gpio control write word: bit positions
  localparam int GPIO_CTRL_WIDTH = 3;
  localparam int GPIO_CTRL_MODE_BIT = 0;
  localparam int GPIO_CTRL_DIR_BIT = 1;
  localparam int GPIO_CTRL_OUT_BIT = 2;

  typedef enum logic [1:0] {
    RSTPF_HOLD,
    RSTPF_COUNT,
    RSTPF_RUN
  } rstpf_state_t;

endpackage : rstpf_pkg

// [rstpf_ctrl_if.sv]
/*
  carrier between the reset sequencer and the system integration control registers.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface rstpf_ctrl_if #(
  parameter int NUM_PINS = rstpf_pkg::NUM_SHARED_PINS
);
  logic chip_reset;
  logic [NUM_PINS-1:0] func_alt;
  logic gpio_mode;
  logic gpio_dir;
  logic gpio_out;

  modport seq (
    output chip_reset,
    input func_alt,
    input gpio_mode,
    input gpio_dir,
    input gpio_out
  );

  modport ctrl (
    input chip_reset,
    output func_alt,
    output gpio_mode,
    output gpio_dir,
    output gpio_out
  );
endinterface : rstpf_ctrl_if
`default_nettype wire

// [rstpf_sim_ctrl.sv]
/*
  system integration control: pin function selection and reset pin gpio settings.
  assumes chip_reset is a registered, synchronous internal reset from the sequencer.
*/
`timescale 1ns/1ns
`default_nettype none
module rstpf_sim_ctrl #(
  parameter int NUM_PINS = rstpf_pkg::NUM_SHARED_PINS
) (
  input wire logic clock,
  input wire logic func_sel_we,
  input wire logic [NUM_PINS-1:0] func_sel_wdata,
  input wire logic gpio_ctrl_we,
  input wire logic [rstpf_pkg::GPIO_CTRL_WIDTH-1:0] gpio_ctrl_wdata,
  rstpf_ctrl_if.ctrl ctrl
);

  ////////////////////////////////////////////////////////////////////////////////
  // per pin selection; only a software write moves a pin off its primary
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge clock) begin
        if (ctrl.chip_reset) begin
          ctrl.func_alt[i] <= rstpf_pkg::FUNC_PRIMARY;
        end else if (func_sel_we) begin
          ctrl.func_alt[i] <= func_sel_wdata[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // reset pin gpio settings; mode and direction cleared, output set, by every reset so the pin comes back as reset input
  always_ff @(posedge clock) begin
    if (ctrl.chip_reset) begin
      ctrl.gpio_mode <= rstpf_pkg::GPIO_MODE_RESET;
      ctrl.gpio_dir <= rstpf_pkg::GPIO_DIR_RESET;
      ctrl.gpio_out <= rstpf_pkg::GPIO_OUT_RESET;
    end else if (gpio_ctrl_we) begin
      ctrl.gpio_mode <= gpio_ctrl_wdata[rstpf_pkg::GPIO_CTRL_MODE_BIT];
      ctrl.gpio_dir <= gpio_ctrl_wdata[rstpf_pkg::GPIO_CTRL_DIR_BIT];
      ctrl.gpio_out <= gpio_ctrl_wdata[rstpf_pkg::GPIO_CTRL_OUT_BIT];
    end
  end

endmodule : rstpf_sim_ctrl
`default_nettype wire

// [rstpf_top.sv]
/*
  reset pin sequencer: filters the external reset pin, merges reset sources, times the
  release of the internal reset and drives the pin as open-drain gpio when selected.
  assumes reset is the power-on reset, synchronous to clock; watchdog and software
  requests come from logic on the same clock; the pin is asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module rstpf_top #(
  parameter int NUM_PINS = rstpf_pkg::NUM_SHARED_PINS,
  parameter int RELEASE_CYCLES = rstpf_pkg::RELEASE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic reset_pin_n_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic watchdog_reset_source,
  input wire logic software_reset,
  input wire logic func_sel_we,
  input wire logic [NUM_PINS-1:0] func_sel_wdata,
  input wire logic gpio_ctrl_we,
  input wire logic [rstpf_pkg::GPIO_CTRL_WIDTH-1:0] gpio_ctrl_wdata,
  output logic chip_reset,
  output logic [NUM_PINS-1:0] pin_func_alt,
  output logic reset_pin_general_io_mode,
  output logic reset_pin_gpio_in
);

  localparam int CW = rstpf_pkg::RELEASE_COUNT_WIDTH;
  localparam logic [CW-1:0] LAST_COUNT = CW'(RELEASE_CYCLES - 1);

  rstpf_ctrl_if #(.NUM_PINS(NUM_PINS)) ctrl_bus ();

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser; stage one feeds only stage two
  logic pin_sync1;
  logic pin_sync2;
  logic pin_sync3;
  logic pin_level;

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_sync1 <= rstpf_pkg::PIN_LEVEL_RESET;
      pin_sync2 <= rstpf_pkg::PIN_LEVEL_RESET;
      pin_sync3 <= rstpf_pkg::PIN_LEVEL_RESET;
    end else begin
      pin_sync1 <= reset_pin_n_in;
      pin_sync2 <= pin_sync1;
      pin_sync3 <= pin_sync2;
    end
  end

  // level changes only once stages two and three agree, which also drops single glitches
  wire pin_stable = (pin_sync2 == pin_sync3);
  wire next_pin_level = pin_stable ? pin_sync3 : pin_level;

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_level <= rstpf_pkg::PIN_LEVEL_RESET;
    end else begin
      pin_level <= next_pin_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset source merge
  wire gpio_mode = ctrl_bus.gpio_mode;
  wire pin_reset_req = ~pin_level & ~gpio_mode;
  wire any_reset = reset | watchdog_reset_source | software_reset | pin_reset_req;

  ////////////////////////////////////////////////////////////////////////////////
  // release sequencer
  rstpf_pkg::rstpf_state_t state;
  rstpf_pkg::rstpf_state_t next_state;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  wire count_done = (count == LAST_COUNT);

  always_comb begin
    next_state = state;
    next_count = count;
    if (any_reset) begin
      next_state = rstpf_pkg::RSTPF_HOLD;
      next_count = '0;
    end else begin
      case (state)
        rstpf_pkg::RSTPF_HOLD: begin
          next_state = rstpf_pkg::RSTPF_COUNT;
          next_count = '0;
        end
        rstpf_pkg::RSTPF_COUNT: begin
          if (count_done) begin
            next_state = rstpf_pkg::RSTPF_RUN;
          end else begin
            next_count = count + CW'(1);
          end
        end
        rstpf_pkg::RSTPF_RUN: begin
          next_state = rstpf_pkg::RSTPF_RUN;
        end
        default: begin
          next_state = rstpf_pkg::RSTPF_HOLD;
          next_count = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= rstpf_pkg::RSTPF_HOLD;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // registered so the internal reset drops on a clock edge
  wire next_chip_reset = (next_state != rstpf_pkg::RSTPF_RUN);

  always_ff @(posedge clock) begin
    if (reset) begin
      chip_reset <= 1'b1;
    end else begin
      chip_reset <= next_chip_reset;
    end
  end

  assign ctrl_bus.chip_reset = chip_reset;

  ////////////////////////////////////////////////////////////////////////////////
  // selection registers
  rstpf_sim_ctrl #(.NUM_PINS(NUM_PINS)) u_sim_ctrl (
    .clock(clock),
    .func_sel_we(func_sel_we),
    .func_sel_wdata(func_sel_wdata),
    .gpio_ctrl_we(gpio_ctrl_we),
    .gpio_ctrl_wdata(gpio_ctrl_wdata),
    .ctrl(ctrl_bus)
  );

  assign pin_func_alt = ctrl_bus.func_alt;
  assign reset_pin_general_io_mode = gpio_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // open-drain drive: only ever pulls low, so a board pull-up can never fight it
  wire drive_low = gpio_mode & ctrl_bus.gpio_dir & ~ctrl_bus.gpio_out;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = drive_low;

  always_ff @(posedge clock) begin
    if (reset) begin
      reset_pin_gpio_in <= rstpf_pkg::PIN_LEVEL_RESET;
    end else begin
      reset_pin_gpio_in <= next_pin_level;
    end
  end

endmodule : rstpf_top
`default_nettype wire

// [rstpf_checker.sv]
/* checker: port properties of the reset pin sequencer.
   assumes one clock and a bind onto rstpf_top. */
`timescale 1ns/1ns
`default_nettype none
module rstpf_checker #(
  parameter int NUM_PINS = 16,
  parameter int RELEASE_CYCLES = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic reset_pin_n_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic watchdog_reset_source,
  input wire logic software_reset,
  input wire logic func_sel_we,
  input wire logic [NUM_PINS-1:0] func_sel_wdata,
  input wire logic gpio_ctrl_we,
  input wire logic [rstpf_pkg::GPIO_CTRL_WIDTH-1:0] gpio_ctrl_wdata,
  input wire logic chip_reset,
  input wire logic [NUM_PINS-1:0] pin_func_alt,
  input wire logic reset_pin_general_io_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // quiet edges since the last request; pin low only counts outside gpio mode
  logic [15:0] quiet;
  always_ff @(posedge clock) begin
    if (reset || software_reset || watchdog_reset_source
        || (!reset_pin_n_in && !reset_pin_general_io_mode)) begin
      quiet <= 16'h0000;
    end else if (quiet != 16'hffff) begin
      quiet <= quiet + 16'h0001;
    end
  end
  sequence s_pin_low;
    (!reset_pin_n_in && !reset_pin_general_io_mode) [*6];
  endsequence
  sequence s_gpio_held;
    reset_pin_general_io_mode [*2];
  endsequence
  ////////////////////////////////////////
  a_src_raises: assert property ((software_reset || watchdog_reset_source) |=> chip_reset)
    else $error("internal source did not raise chip reset");
  a_pin_resets: assert property (s_pin_low |-> chip_reset)
    else $error("pin low did not reset the chip");
  a_release_gap: assert property ($fell(chip_reset) |-> quiet > RELEASE_CYCLES)
    else $error("chip reset released too early");
  a_reset_clears: assert property (chip_reset |=> pin_func_alt == '0
    && !reset_pin_general_io_mode) else $error("reset left a selection set");
  a_func_write: assert property (!chip_reset && func_sel_we |=>
    pin_func_alt == $past(func_sel_wdata)) else $error("function write lost");
  a_func_hold: assert property (!chip_reset && !func_sel_we |=> $stable(pin_func_alt))
    else $error("function selection changed unasked");
  a_gpio_write: assert property (!chip_reset && gpio_ctrl_we |=>
    reset_pin_general_io_mode == $past(gpio_ctrl_wdata[0])
    && reset_pin_oe == ($past(gpio_ctrl_wdata) == 3'h3)) else $error("gpio write wrong");
  a_open_drain: assert property (!reset_pin_out && (!reset_pin_oe || reset_pin_general_io_mode))
    else $error("pin driven push-pull or outside gpio mode");
  a_pin_ignored: assert property (s_gpio_held ##0 !(software_reset || watchdog_reset_source
    || chip_reset) |=> !chip_reset) else $error("pin reset in gpio mode");
endmodule : rstpf_checker
bind rstpf_top rstpf_checker #(.NUM_PINS(NUM_PINS), .RELEASE_CYCLES(RELEASE_CYCLES)) chk (
  .clock, .reset, .reset_pin_n_in, .reset_pin_out, .reset_pin_oe, .watchdog_reset_source,
  .software_reset, .func_sel_we, .func_sel_wdata, .gpio_ctrl_we, .gpio_ctrl_wdata,
  .chip_reset, .pin_func_alt, .reset_pin_general_io_mode);
`default_nettype wire

// [rstpf_pin_model.sv]
/* board reset source on the reset pin.
   assumes a pull-up on the pin and open drain on both sides. */
`timescale 1ns/1ns
`default_nettype none
module rstpf_pin_model (
  input wire logic pull_low,
  input wire logic device_oe,
  output logic pin_level
);
  // wired-and: the pull-up wins only while nobody pulls low
  assign pin_level = !(pull_low || device_oe);
endmodule : rstpf_pin_model
`default_nettype wire

// [reset_pin_and_pin_function_select_tb_top.sv]
/* self-checking bench for rstpf_top with a board reset source.
   assumes the checker is bound through its own file. */
`timescale 1ns/1ns
`default_nettype none
module reset_pin_and_pin_function_select_tb_top;
  localparam int RC = 4;
  logic clock, reset, reset_pin_n_in, reset_pin_out, reset_pin_oe, watchdog_reset_source;
  logic software_reset, func_sel_we, gpio_ctrl_we, chip_reset, reset_pin_general_io_mode;
  logic reset_pin_gpio_in, pull_low;
  logic [15:0] func_sel_wdata, pin_func_alt, v;
  logic [2:0] gpio_ctrl_wdata;
  int n_errors, tests_run, cycles, n, i;
  rstpf_top #(.NUM_PINS(16), .RELEASE_CYCLES(RC)) dut (.clock, .reset, .reset_pin_n_in,
    .reset_pin_out, .reset_pin_oe, .watchdog_reset_source, .software_reset, .func_sel_we,
    .func_sel_wdata, .gpio_ctrl_we, .gpio_ctrl_wdata, .chip_reset, .pin_func_alt,
    .reset_pin_general_io_mode, .reset_pin_gpio_in);
  rstpf_pin_model pm (.pull_low(pull_low), .device_oe(reset_pin_oe), .pin_level(reset_pin_n_in));
  ////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick
  task wfunc(input logic [15:0] d);
    func_sel_we = 1'b1;
    func_sel_wdata = d;
    tick(1);
    func_sel_we = 1'b0;
    // one idle edge, so a following write never re-raises the strobe in this time step
    tick(1);
  endtask : wfunc
  task wgpio(input logic [2:0] d);
    gpio_ctrl_we = 1'b1;
    gpio_ctrl_wdata = d;
    tick(1);
    gpio_ctrl_we = 1'b0;
    tick(1);
  endtask : wgpio
  // release must wait longer than the count, pin filter adds a few edges
  function logic late_enough(input int k);
    return k > RC && k < RC + 9;
  endfunction : late_enough
  task wait_release;
    n = 0;
    while (chip_reset !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    check(late_enough(n), 1'b1);
    check(pin_func_alt, 16'h0000);
    check(reset_pin_general_io_mode, 1'b0);
  endtask : wait_release
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {reset, pull_low, software_reset, watchdog_reset_source} = 4'h8;
    {func_sel_we, gpio_ctrl_we, func_sel_wdata, gpio_ctrl_wdata} = '0;
    void'($urandom(32));
    tick(6);
    reset = 1'b0;
    wait_release();
    for (i = 0; i < 10; i++) begin
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      wfunc(v);
      check(pin_func_alt, v);
    end
    // each internal source, a write inside reset, then a restart on the last count edge
    for (i = 0; i < 2; i++) begin
      wfunc(16'ha5c3);
      wgpio(3'h1);
      {software_reset, watchdog_reset_source} = (i == 0) ? 2'h2 : 2'h1;
      tick(2);
      {software_reset, watchdog_reset_source} = 2'h0;
      wfunc(16'h00ff);
      tick(2);
      software_reset = 1'b1;
      tick(1);
      software_reset = 1'b0;
      wait_release();
    end
    wgpio(3'h3);
    check({reset_pin_oe, reset_pin_general_io_mode}, 2'h3);
    check(reset_pin_out, 1'b0);
    tick(8);
    check({chip_reset, reset_pin_gpio_in}, 2'h0);
    wgpio(3'h7);
    check(reset_pin_oe, 1'b0);
    pull_low = 1'b1;
    tick(8);
    check({chip_reset, reset_pin_gpio_in}, 2'h0);
    pull_low = 1'b0;
    tick(6);
    wgpio(3'h0);
    pull_low = 1'b1;
    tick(8);
    check(chip_reset, 1'b1);
    pull_low = 1'b0;
    wait_release();
    // power-on reset in mid-run while the pin sits in general io mode
    wgpio(3'h1);
    check(reset_pin_general_io_mode, 1'b1);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    wait_release();
    give_verdict();
  end
endmodule : reset_pin_and_pin_function_select_tb_top
`default_nettype wire
